// ===== design/lpm_consts.vh
// Constants for the low power mode controller: register map, fields, resets, timing.
// Assumes inclusion by bare name from design files.
`ifndef LPM_CONSTS_VH
`define LPM_CONSTS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define LPM_CTRL_ADDR     12'h000
`define LPM_WAKE_CFG_ADDR 12'h004
`define LPM_TIMEOUT_ADDR  12'h008
`define LPM_STATUS_ADDR   12'h00C
`define LPM_RETAIN_ADDR   12'h010
`define LPM_CLKSEL_ADDR   12'h014

// ----------------------------------------
// Mode request codes (control bits 2:0)
// ----------------------------------------
`define MODE_ACTIVE   3'h0
`define MODE_IDLE     3'h1
`define MODE_SLEEP    3'h2
`define MODE_PDS      3'h3
`define MODE_EXTENDED_POWER_DOWN_SLEEP     3'h4
`define MODE_DEEP_OFF 3'h5

// ----------------------------------------
// Slow clock source codes
// ----------------------------------------
`define SRC_LP_OSC    2'h0
`define SRC_HA_OSC    2'h1
`define SRC_EXT_XTAL  2'h2

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CTRL_GO_BIT       3
`define WAKE_TMR_EN_BIT   0
`define WAKE_GPIO_EN_BIT  1
`define RETAIN_OFF_BIT    0
`define RETAIN_TMR_BIT    1
`define RETAIN_GPIO_BIT   2
`define WAKE_CFG_RESET    2'h3
`define TIMEOUT_RESET     32'h0000_8000
`define CLKSEL_RESET      2'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define SYS_CLK_MHZ       100
`define MAIN_XTAL_MHZ     24
`define IDLE_DIV          8

`endif

// ===== design/slow_tick_select.v
// Slow clock source selector: synchronises three slow oscillator inputs and
// produces a one-cycle tick on each rising edge of the chosen source.
// Assumes the oscillator inputs are asynchronous to sys_clk.
`timescale 1ns/100ps
`default_nettype none
`include "lpm_consts.vh"

module slow_tick_select (
	input  wire       sys_clk,
	input  wire       reset_n,
	input  wire [1:0] source_sel,
	input  wire       low_power_internal_osc,
	input  wire       high_accuracy_internal_osc,
	input  wire       external_slow_crystal,
	input  wire       enable,
	output reg        slow_tick,
	output wire       slow_clock
);

	reg  [2:0] sync_a;
	reg  [2:0] sync_b;
	reg        prev;
	reg        chosen;

	// ----------------------------------------
	// Two-stage synchronisers
	// ----------------------------------------
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_a <= 3'h0;
			sync_b <= 3'h0;
		end else begin
			sync_a <= {external_slow_crystal, high_accuracy_internal_osc,
				low_power_internal_osc};
			sync_b <= sync_a;
		end
	end

	always @* begin
		if (source_sel == `SRC_EXT_XTAL)
			chosen = sync_b[2];
		else if (source_sel == `SRC_HA_OSC)
			chosen = sync_b[1];
		else
			chosen = sync_b[0];
	end

	// Gated off in deep off: that source then stops delivering time
	assign slow_clock = chosen & enable;

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			prev      <= 1'b0;
			slow_tick <= 1'b0;
		end else begin
			prev      <= slow_clock;
			slow_tick <= slow_clock & ~prev;
		end
	end

endmodule
`default_nettype wire

// ===== design/low_power_mode_controller.v
// Low power mode controller: six power states, clock gating, wake logic.
// Assumes an APB master on sys_clk and asynchronous wake and oscillator pins.
`timescale 1ns/100ps
`default_nettype none
`include "lpm_consts.vh"

module low_power_mode_controller #(
	parameter IDLE_DIV = `IDLE_DIV
) (
	input  wire        sys_clk,
	input  wire        reset_n,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	input  wire        main_xtal_clk,
	input  wire        low_power_internal_osc,
	input  wire        high_accuracy_internal_osc,
	input  wire        external_slow_crystal,
	input  wire        gpio_wake,
	input  wire        clocks_idle_ok,
	output reg         cpu_run,
	output reg         wait_for_interrupt_state,
	output reg         periph_enable,
	output reg         bus_clk_en,
	output reg         aux_clk_en,
	output reg         slow_clock_en,
	output reg         regulator_low_v,
	output reg         radio_power,
	output reg         core_power,
	output reg         retention_power,
	output reg         regulator_power,
	output reg         full_init_req,
	output wire        slow_clock,
	output wire [5:0]  power_state
);

	// ----------------------------------------
	// States, one-hot
	// ----------------------------------------
	localparam [5:0] ST_ACTIVE   = 6'h01;
	localparam [5:0] ST_IDLE     = 6'h02;
	localparam [5:0] ST_SLEEP    = 6'h04;
	localparam [5:0] ST_PDS      = 6'h08;
	localparam [5:0] ST_EXTENDED_POWER_DOWN_SLEEP     = 6'h10;
	localparam [5:0] ST_DEEP_OFF = 6'h20;

	reg  [5:0]  state;
	reg  [5:0]  next_state;
	reg  [2:0]  mode_req;
	reg  [1:0]  wake_cfg;
	reg  [31:0] timeout;
	reg  [31:0] tmr_count;
	reg  [2:0]  retain;
	reg  [1:0]  clk_src;
	reg         go;
	reg  [1:0]  gpio_sync;
	reg         gpio_prev;
	reg  [1:0]  xtal_sync;
	reg         xtal_prev;
	reg  [7:0]  div_count;
	reg         hclk_tick;
	wire        slow_tick;
	wire        gpio_rise;
	wire        tmr_hit;
	wire        wake;
	wire        sleeping;
	wire        wr_en;

	// Unused mode codes map to active
	function [5:0] mode_to_state;
		input [2:0] mode;
		begin
			if (mode == `MODE_IDLE)
				mode_to_state = ST_IDLE;
			else if (mode == `MODE_SLEEP)
				mode_to_state = ST_SLEEP;
			else if (mode == `MODE_PDS)
				mode_to_state = ST_PDS;
			else if (mode == `MODE_EXTENDED_POWER_DOWN_SLEEP)
				mode_to_state = ST_EXTENDED_POWER_DOWN_SLEEP;
			else if (mode == `MODE_DEEP_OFF)
				mode_to_state = ST_DEEP_OFF;
			else
				mode_to_state = ST_ACTIVE;
		end
	endfunction

	assign power_state = state;
	assign sleeping    = (state == ST_SLEEP) | (state == ST_PDS) |
		(state == ST_EXTENDED_POWER_DOWN_SLEEP) | (state == ST_DEEP_OFF);

	// ----------------------------------------
	// APB slave, zero wait states
	// ----------------------------------------
	// No wait states: every register answers in the access phase
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	// Writes land at the access edge only
	assign wr_en   = psel & penable & pwrite;

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_req <= `MODE_ACTIVE;
			wake_cfg <= `WAKE_CFG_RESET;
			timeout  <= `TIMEOUT_RESET;
			clk_src  <= `CLKSEL_RESET;
			go       <= 1'b0;
		end else begin
			// Go lasts one cycle, so a stored mode is never applied twice
			go <= 1'b0;
			if (wr_en) begin
				if (paddr == `LPM_CTRL_ADDR) begin
					mode_req <= pwdata[2:0];
					go       <= pwdata[`CTRL_GO_BIT];
				end else if (paddr == `LPM_WAKE_CFG_ADDR) begin
					wake_cfg <= pwdata[1:0];
				end else if (paddr == `LPM_TIMEOUT_ADDR) begin
					timeout <= pwdata;
				end else if (paddr == `LPM_CLKSEL_ADDR) begin
					clk_src <= pwdata[1:0];
				end
			end
		end
	end

	// ----------------------------------------
	// Read data, captured in the setup phase
	// ----------------------------------------
	// A flop keeps the word steady through the access phase,
	// even when the state changes underneath it
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel & ~penable) begin
			if (paddr == `LPM_CTRL_ADDR)
				prdata <= {29'h0000000, mode_req};
			else if (paddr == `LPM_WAKE_CFG_ADDR)
				prdata <= {30'h0000000, wake_cfg};
			else if (paddr == `LPM_TIMEOUT_ADDR)
				prdata <= timeout;
			else if (paddr == `LPM_STATUS_ADDR)
				prdata <= {26'h000000, state};
			else if (paddr == `LPM_RETAIN_ADDR)
				prdata <= {29'h0000000, retain};
			else if (paddr == `LPM_CLKSEL_ADDR)
				prdata <= {30'h0000000, clk_src};
			else
				prdata <= 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Slow clock source and wake timer
	// ----------------------------------------
	// Driven clock or crystal look alike once synchronised
	slow_tick_select u_slow (
		.sys_clk                    (sys_clk),
		.reset_n                    (reset_n),
		.source_sel                 (clk_src),
		.low_power_internal_osc     (low_power_internal_osc),
		.high_accuracy_internal_osc (high_accuracy_internal_osc),
		.external_slow_crystal      (external_slow_crystal),
		.enable                     (slow_clock_en),
		.slow_tick                  (slow_tick),
		.slow_clock                 (slow_clock)
	);

	// Cleared outside the sleep states, so each entry times afresh
	// In deep off time still runs from low_power_internal_osc ungated, whatever source is selected
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tmr_count <= 32'h0000_0000;
		end else if (!sleeping) begin
			tmr_count <= 32'h0000_0000;
		end else if (slow_tick | (state == ST_DEEP_OFF && xtal_sync[1] & ~xtal_prev)) begin
			tmr_count <= tmr_count + 32'h0000_0001;
		end
	end
	assign tmr_hit = wake_cfg[`WAKE_TMR_EN_BIT] && (tmr_count >= timeout);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			gpio_sync <= 2'h0;
			gpio_prev <= 1'b0;
			xtal_sync <= 2'h0;
			xtal_prev <= 1'b0;
		end else begin
			gpio_sync <= {gpio_sync[0], gpio_wake};
			gpio_prev <= gpio_sync[1];
			xtal_sync <= {xtal_sync[0], low_power_internal_osc};
			xtal_prev <= xtal_sync[1];
		end
	end
	// Edge detector resets low like an idle pin: no false wake
	assign gpio_rise = wake_cfg[`WAKE_GPIO_EN_BIT] & gpio_sync[1] & ~gpio_prev;
	assign wake      = sleeping & (tmr_hit | gpio_rise);

	// ----------------------------------------
	// Bus clock divider from main crystal clock
	// ----------------------------------------
	// Main crystal clock sampled as a level; bus clock enable follows its edges
	// Main clock must stay below half of sys_clk, or edges are lost
	// Divider runs free, so idle needs no restart on entry
	reg [1:0] main_sync;
	reg       main_prev;
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			main_sync <= 2'h0;
			main_prev <= 1'b0;
			div_count <= 8'h00;
			hclk_tick <= 1'b0;
		end else begin
			main_sync <= {main_sync[0], main_xtal_clk};
			main_prev <= main_sync[1];
			hclk_tick <= 1'b0;
			if (main_sync[1] & ~main_prev) begin
				if (div_count >= IDLE_DIV[7:0] - 8'h01) begin
					div_count <= 8'h00;
					hclk_tick <= 1'b1;
				end else begin
					div_count <= div_count + 8'h01;
				end
			end
		end
	end

	// ----------------------------------------
	// Power state machine
	// ----------------------------------------
	always @* begin
		next_state = state;
		case (state)
			ST_ACTIVE: begin
				if (go)
					next_state = mode_to_state(mode_req);
			end
			ST_IDLE: begin
				if (go)
					next_state = mode_to_state(mode_req);
			end
			// Low power states leave only on a wake, never on a write
			ST_SLEEP, ST_PDS, ST_EXTENDED_POWER_DOWN_SLEEP, ST_DEEP_OFF: begin
				if (wake)
					next_state = ST_ACTIVE;
			end
			// Illegal codes recover to active
			default: begin
				next_state = ST_ACTIVE;
			end
		endcase
	end

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			state <= ST_ACTIVE;
		else
			state <= next_state;
	end

	// Retained indications; written only on wake, cleared by writing ones
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			retain        <= 3'h0;
			full_init_req <= 1'b0;
		end else begin
			full_init_req <= 1'b0;
			if (wr_en && paddr == `LPM_RETAIN_ADDR)
				retain <= retain & ~pwdata[2:0];
			// After the clear, so a wake in the same cycle wins
			if (wake) begin
				retain[`RETAIN_TMR_BIT]  <= tmr_hit;
				retain[`RETAIN_GPIO_BIT] <= gpio_rise;
				if (state == ST_DEEP_OFF) begin
					retain[`RETAIN_OFF_BIT] <= 1'b1;
					full_init_req           <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// Output decode per state
	// ----------------------------------------
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			// Reset leaves the chip running and fully powered
			cpu_run                  <= 1'b1;
			wait_for_interrupt_state <= 1'b0;
			periph_enable            <= 1'b1;
			bus_clk_en               <= 1'b1;
			aux_clk_en               <= 1'b1;
			slow_clock_en            <= 1'b1;
			regulator_low_v          <= 1'b0;
			radio_power              <= 1'b1;
			core_power               <= 1'b1;
			retention_power          <= 1'b1;
			regulator_power          <= 1'b1;
		end else begin
			// Registered, so every output trails the state by one cycle
			cpu_run                  <= (state == ST_ACTIVE);
			periph_enable            <= (state == ST_ACTIVE) | (state == ST_IDLE);
			wait_for_interrupt_state <= (state == ST_IDLE) | (state == ST_SLEEP);
			aux_clk_en               <= (state == ST_ACTIVE) | (state == ST_IDLE) |
				((state == ST_SLEEP) & ~clocks_idle_ok);
			// Deep off stops the slow clock; the timer counts synchronised low_power_internal_osc edges
			slow_clock_en            <= (state != ST_DEEP_OFF);
			regulator_low_v          <= (state == ST_SLEEP) | (state == ST_PDS);
			radio_power              <= (state == ST_ACTIVE) | (state == ST_IDLE) |
				(state == ST_SLEEP);
			core_power               <= (state == ST_ACTIVE) | (state == ST_IDLE) |
				(state == ST_SLEEP);
			retention_power          <= (state != ST_DEEP_OFF);
			regulator_power          <= (state != ST_DEEP_OFF);
			// Bus clock enable follows main crystal rises, divided in idle
			if (state == ST_ACTIVE)
				bus_clk_en <= main_sync[1] & ~main_prev;
			else if (state == ST_IDLE)
				bus_clk_en <= hclk_tick;
			else
				bus_clk_en <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ===== verification/lpm_chk.sv
// Port checker for the low power mode controller.
// Assumes binding to the design top; everything on sys_clk.
`timescale 1ns/100ps
`default_nettype none
module lpm_chk #(
	parameter IDLE_DIV = 8
) (
	input wire       sys_clk,
	input wire       reset_n,
	input wire       psel,
	input wire       penable,
	input wire       pwrite,
	input wire       pready,
	input wire       pslverr,
	input wire       clocks_idle_ok,
	input wire       cpu_run,
	input wire       wait_for_interrupt_state,
	input wire       periph_enable,
	input wire       bus_clk_en,
	input wire       aux_clk_en,
	input wire       slow_clock_en,
	input wire       regulator_low_v,
	input wire       radio_power,
	input wire       core_power,
	input wire       retention_power,
	input wire       regulator_power,
	input wire       full_init_req,
	input wire       slow_clock,
	input wire [5:0] power_state
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	// Outputs lag the state by a cycle, so the per-state output checks judge only settled states
	one_state_a: assert property ($onehot(power_state))
		else $error("power state not one-hot");
	active_run_a: assert property (power_state == 6'h01 && $stable(power_state)
		|-> cpu_run && periph_enable && core_power) else $error("active outputs wrong");
	idle_wait_a: assert property (power_state == 6'h02 && $stable(power_state)
		|-> wait_for_interrupt_state && !cpu_run && periph_enable && aux_clk_en)
		else $error("idle outputs wrong");
	sleep_clock_a: assert property (power_state == 6'h04 && $stable(power_state)
		|-> wait_for_interrupt_state && !bus_clk_en && slow_clock_en && regulator_low_v)
		else $error("sleep outputs wrong");
	aux_gate_a: assert property ((power_state == 6'h04 && clocks_idle_ok)[*4]
		|-> !aux_clk_en) else $error("aux clock not stopped");
	pds_power_a: assert property (power_state == 6'h08 && $stable(power_state)
		|-> !radio_power && !core_power && retention_power) else $error("pds power wrong");
	extended_power_down_sleep_power_a: assert property (power_state == 6'h10 && $stable(power_state)
		|-> !radio_power && !core_power && retention_power) else $error("extended_power_down_sleep power wrong");
	deep_off_a: assert property (power_state == 6'h20 && $stable(power_state)
		|-> !regulator_power && !slow_clock_en && !core_power && !slow_clock)
		else $error("deep off power wrong");
	off_init_a: assert property (power_state == 6'h20 ##1 power_state == 6'h01
		|-> ##[0:3] full_init_req) else $error("no init after deep off");
	fw_entry_a: assert property ($fell(power_state[0])
		|-> $past(psel && penable && pwrite, 2)) else $error("state left without write");
	apb_ready_a: assert property (psel && penable |-> pready && !pslverr)
		else $error("apb answer wrong");
endmodule
bind low_power_mode_controller lpm_chk #(.IDLE_DIV(IDLE_DIV)) chk_i (
	.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pready(pready), .pslverr(pslverr), .clocks_idle_ok(clocks_idle_ok),
	.cpu_run(cpu_run), .wait_for_interrupt_state(wait_for_interrupt_state),
	.periph_enable(periph_enable), .bus_clk_en(bus_clk_en), .aux_clk_en(aux_clk_en),
	.slow_clock_en(slow_clock_en), .regulator_low_v(regulator_low_v),
	.radio_power(radio_power), .core_power(core_power), .retention_power(retention_power),
	.regulator_power(regulator_power), .full_init_req(full_init_req),
	.slow_clock(slow_clock), .power_state(power_state));
`default_nettype wire

// ===== verification/low_power_mode_controller_tb.sv
// Testbench for the low power mode controller over APB.
// Assumes the design and its constants header are on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "lpm_consts.vh"
module low_power_mode_controller_tb;
	logic        sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic        main_xtal_clk = 0, low_power_internal_osc = 0;
	logic        high_accuracy_internal_osc = 0, external_slow_crystal = 0;
	logic        gpio_wake = 0, clocks_idle_ok = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] rd;
	wire  [31:0] prdata;
	wire  [5:0]  power_state;
	wire         pready, pslverr, cpu_run, wait_for_interrupt_state, periph_enable;
	wire         bus_clk_en, aux_clk_en, slow_clock_en, regulator_low_v, radio_power;
	wire         core_power, retention_power, regulator_power, full_init_req, slow_clock;
	int          n_mismatch = 0, checked = 0, n;
	// Idle divisor of 4 keeps the pulse count window short
	low_power_mode_controller #(.IDLE_DIV(4)) uut (
		.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .main_xtal_clk(main_xtal_clk),
		.low_power_internal_osc(low_power_internal_osc),
		.high_accuracy_internal_osc(high_accuracy_internal_osc),
		.external_slow_crystal(external_slow_crystal), .gpio_wake(gpio_wake),
		.clocks_idle_ok(clocks_idle_ok), .cpu_run(cpu_run),
		.wait_for_interrupt_state(wait_for_interrupt_state), .periph_enable(periph_enable),
		.bus_clk_en(bus_clk_en), .aux_clk_en(aux_clk_en), .slow_clock_en(slow_clock_en),
		.regulator_low_v(regulator_low_v), .radio_power(radio_power),
		.core_power(core_power), .retention_power(retention_power),
		.regulator_power(regulator_power), .full_init_req(full_init_req),
		.slow_clock(slow_clock), .power_state(power_state));
	// ----------------------------------------
	// Clocks and sources
	// ----------------------------------------
	initial forever #5 sys_clk = ~sys_clk;
	initial forever #20.8 main_xtal_clk = ~main_xtal_clk;
	initial forever #15625 low_power_internal_osc = ~low_power_internal_osc;
	initial forever #15620 high_accuracy_internal_osc = ~high_accuracy_internal_osc;
	initial forever #15258.8 external_slow_crystal = ~external_slow_crystal;
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task summarize;
		$display("Checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, e, rd);
	endtask
	task cnt_bus;
		n = 0;
		repeat (1000) begin
			@(posedge sys_clk);
			if (bus_clk_en === 1'b1) n++;
		end
	endtask
	task wake_run(input logic [2:0] m, input logic [1:0] sel, input logic [1:0] cfg,
		input logic gp, input logic [31:0] ret);
		logic seen;
		int   k;
		seen = 1'b0;
		apb(1'b1, `LPM_CLKSEL_ADDR, {30'h0, sel});
		apb(1'b1, `LPM_TIMEOUT_ADDR, 32'h0000_0002);
		apb(1'b1, `LPM_WAKE_CFG_ADDR, {30'h0, cfg});
		apb(1'b1, `LPM_RETAIN_ADDR, 32'h0000_0007);
		apb(1'b1, `LPM_CTRL_ADDR, {29'h0000001, m});
		repeat (6) @(posedge sys_clk);
		rdchk("low power state", `LPM_STATUS_ADDR, 32'h1 << m);
		if (m == `MODE_SLEEP) begin
			clocks_idle_ok <= 1'b1;
			repeat (8) @(posedge sys_clk);
			chk("aux clock stopped", 32'h0, aux_clk_en);
			clocks_idle_ok <= 1'b0;
		end
		if (gp) begin
			gpio_wake <= 1'b1;
			for (k = 0; k < 20; k++) begin
				@(posedge sys_clk);
				if (k == 9) gpio_wake <= 1'b0;
				if (full_init_req === 1'b1) seen = 1'b1;
			end
		end
		if (gp && !cfg[1]) rdchk("gpio masked", `LPM_STATUS_ADDR, 32'h1 << m);
		for (k = 0; k < 15000 && cpu_run !== 1'b1; k++) begin
			@(posedge sys_clk);
			if (full_init_req === 1'b1) seen = 1'b1;
		end
		repeat (3) begin
			@(posedge sys_clk);
			if (full_init_req === 1'b1) seen = 1'b1;
		end
		chk("woke to run", 32'h1, cpu_run);
		chk("full init", m == `MODE_DEEP_OFF, seen);
		rdchk("back active", `LPM_STATUS_ADDR, 32'h1);
		rdchk("wake cause", `LPM_RETAIN_ADDR, ret);
		$display("Test done: wake from mode %0d", m);
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		#800000;
		n_mismatch++;
		summarize;
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		rdchk("status reset", `LPM_STATUS_ADDR, 32'h1);
		rdchk("wake cfg reset", `LPM_WAKE_CFG_ADDR, 32'h3);
		rdchk("timeout reset", `LPM_TIMEOUT_ADDR, 32'h0000_8000);
		rdchk("clksel reset", `LPM_CLKSEL_ADDR, 32'h0);
		apb(1'b1, 12'h020, 32'hFFFF_FFFF);
		rdchk("unmapped", 12'h020, 32'h0);
		chk("run after reset", 32'h1, cpu_run);
		$display("Test done: reset values");
		cnt_bus;
		chk("active bus rate", 32'h1, n >= 239 && n <= 241);
		apb(1'b1, `LPM_CTRL_ADDR, 32'h0000_0002);
		repeat (6) @(posedge sys_clk);
		rdchk("no go no change", `LPM_STATUS_ADDR, 32'h1);
		apb(1'b1, `LPM_CTRL_ADDR, 32'h0000_0009);
		repeat (6) @(posedge sys_clk);
		rdchk("idle state", `LPM_STATUS_ADDR, 32'h2);
		cnt_bus;
		chk("idle bus rate", 32'h1, n >= 59 && n <= 61);
		apb(1'b1, `LPM_CTRL_ADDR, 32'h0000_0008);
		repeat (6) @(posedge sys_clk);
		rdchk("idle to active", `LPM_STATUS_ADDR, 32'h1);
		$display("Test done: bus clock and idle");
		wake_run(`MODE_SLEEP, `SRC_LP_OSC, 2'h2, 1'b1, 32'h4);
		wake_run(`MODE_PDS, `SRC_HA_OSC, 2'h1, 1'b0, 32'h2);
		wake_run(`MODE_EXTENDED_POWER_DOWN_SLEEP, `SRC_EXT_XTAL, 2'h1, 1'b1, 32'h2);
		wake_run(`MODE_DEEP_OFF, `SRC_LP_OSC, 2'h2, 1'b1, 32'h5);
		wake_run(`MODE_DEEP_OFF, `SRC_HA_OSC, 2'h1, 1'b0, 32'h3);
		summarize;
	end
endmodule
`default_nettype wire
